// ===== verilog/lvds_pkg.sv
// ****************************************************************
// limit value delay sender: shared constants
// ****************************************************************
package lvds_pkg;

  // channel counts: gas limits first, humidity limits after
  localparam int NUM_CH = 6;
  localparam int NUM_GAS = 4;
  localparam int NUM_HUM = 2;

  // apb geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [4:0] CH_PAGE = 5'h02; // channel page at 0x100
  localparam logic [1:0] SUB_THR = 2'h0; // threshold and hysteresis
  localparam logic [1:0] SUB_MODE = 2'h1; // source, direction, sending
  localparam logic [1:0] SUB_TIMES = 2'h2; // delays and cycle
  localparam logic [1:0] SUB_ACT = 2'h3; // threshold in force (ro)

  // ctrl fields
  localparam int CTRL_NGAS_LSB = 0;
  localparam int CTRL_NHUM_LSB = 4;
  localparam int CTRL_LOAD_BIT = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0024;

  // mode fields
  localparam int MODE_SRC_LSB = 0;
  localparam int MODE_DIR_BIT = 2; // 0: undershoot on, 1: exceed on
  localparam int MODE_SOC_BIT = 3; // send on change
  localparam int MODE_SON_BIT = 4; // state 1 is sent
  localparam int MODE_SOFF_BIT = 5; // state 0 is sent
  localparam logic [31:0] MODE_RST = 32'h0000_0038;
  localparam logic [31:0] THR_RST = 32'h0000_0000;

  // times fields, all in base ticks
  localparam int TIMES_ON_LSB = 0;
  localparam int TIMES_OFF_LSB = 8;
  localparam int TIMES_CYC_LSB = 16;
  localparam logic [31:0] TIMES_RST = 32'h0000_0000;

  // status fields
  localparam int STAT_INT_LSB = 0;
  localparam int STAT_DLY_LSB = 8;
  localparam int STAT_PEND_LSB = 16;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint TICK_TIME_MS = 100;
  localparam longint TICK_CYCLES_DEF =
    (TICK_TIME_MS * 64'd1_000_000_000) / CLK_PERIOD_PS;

  // percentage scaling: full scale of each measurement, percent base
  localparam logic [15:0] GAS_FULL_SCALE = 16'h0FA0;
  localparam logic [15:0] HUM_FULL_SCALE = 16'h0064;
  localparam logic [23:0] PCT_BASE = 24'h00_0064;

  // external source selection
  typedef enum logic [1:0] {
    LVDS_SRC_NONE = 2'h0,
    LVDS_SRC_ABS = 2'h1,
    LVDS_SRC_PCT = 2'h2,
    LVDS_SRC_TEACH = 2'h3
  } lvds_src_t;

  // transmit stage states, one-hot
  typedef enum logic [1:0] {
    LVDS_TX_IDLE = 2'b01,
    LVDS_TX_BUSY = 2'b10
  } lvds_tx_t;

endpackage

// ===== verilog/lvds_top.sv
`timescale 1ns/10ps
module lvds_top
  import lvds_pkg::*;
#(
  parameter longint TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] gas_value,
  input wire logic [15:0] hum_value,
  input wire logic ext_valid,
  input wire logic [2:0] ext_index,
  input wire logic [1:0] ext_kind,
  input wire logic [15:0] ext_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [2:0] tx_index,
  output logic tx_value
);

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [31:0] ctrl_reg, ctrl_next; // limit counts
  logic [31:0] thr_cfg_reg [NUM_CH]; // configured threshold, hysteresis
  logic [31:0] thr_cfg_next [NUM_CH];
  logic [31:0] mode_reg [NUM_CH]; // source and sending options
  logic [31:0] mode_next [NUM_CH];
  logic [31:0] times_reg [NUM_CH]; // delays and cycle
  logic [31:0] times_next [NUM_CH];
  logic [31:0] rdata_reg, rdata_next; // read data, caught in setup
  logic err_reg, err_next; // unmapped access flag
  logic load_pulse; // download: reload configured thresholds
  logic [15:0] thr_act [NUM_CH]; // threshold in force per limit
  logic [NUM_CH-1:0] int_st; // internal limit states
  logic [NUM_CH-1:0] dly_st; // delayed limit states
  logic [NUM_CH-1:0] pend; // telegram waiting per limit
  logic [NUM_CH-1:0] grant; // limit taken by transmit stage
  logic [NUM_CH-1:0] ch_on; // limit is active

  // address decode
  logic setup_ph, wr_acc, ch_hit;
  logic [2:0] ch_sel;
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign ch_sel = paddr[6:4];
  assign ch_hit = (paddr[11:7] == CH_PAGE) && (ch_sel < 3'(NUM_CH));
  assign load_pulse = wr_acc && (paddr == REG_CTRL) &&
                      pwdata[CTRL_LOAD_BIT];

  // zero-wait slave, read data and error from the setup cycle
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg;

  // next values for configuration and read path
  always_comb begin
    ctrl_next = ctrl_reg;
    thr_cfg_next = thr_cfg_reg;
    mode_next = mode_reg;
    times_next = times_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    // write at the access edge
    if (wr_acc) begin
      if (paddr == REG_CTRL) begin
        ctrl_next = {26'h0, pwdata[5:4], 1'b0, pwdata[2:0]};
      end else if (ch_hit) begin
        case (paddr[3:2])
          SUB_THR: thr_cfg_next[ch_sel] = pwdata;
          SUB_MODE: mode_next[ch_sel] = {26'h0, pwdata[5:0]};
          SUB_TIMES: times_next[ch_sel] = {8'h0, pwdata[23:0]};
          default: ; // threshold in force is read only
        endcase
      end
    end
    // read data and error in the setup cycle
    if (setup_ph) begin
      err_next = 1'b0;
      rdata_next = 32'h0000_0000;
      if (paddr == REG_CTRL) begin
        rdata_next = ctrl_reg;
      end else if (paddr == REG_STATUS) begin
        rdata_next[STAT_INT_LSB +: NUM_CH] = int_st;
        rdata_next[STAT_DLY_LSB +: NUM_CH] = dly_st;
        rdata_next[STAT_PEND_LSB +: NUM_CH] = pend;
      end else if (ch_hit) begin
        case (paddr[3:2])
          SUB_THR: rdata_next = thr_cfg_reg[ch_sel];
          SUB_MODE: rdata_next = mode_reg[ch_sel];
          SUB_TIMES: rdata_next = times_reg[ch_sel];
          default: rdata_next = {16'h0, thr_act[ch_sel]};
        endcase
      end else begin
        err_next = 1'b1; // unmapped address
      end
    end
  end

  // register the configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        thr_cfg_reg[i] <= THR_RST;
        mode_reg[i] <= MODE_RST;
        times_reg[i] <= TIMES_RST;
      end
    end else begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      thr_cfg_reg <= thr_cfg_next;
      mode_reg <= mode_next;
      times_reg <= times_next;
    end
  end

  // ****************************************************************
  // base tick
  // ****************************************************************
  logic [31:0] pre_reg, pre_next; // prescaler
  logic tick; // one-cycle enable per base tick
  always_comb begin
    tick = (pre_reg == 32'(TICK_CYCLES - 1));
    pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 32'h0000_0000;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // ****************************************************************
  // per-limit processing
  // ****************************************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [15:0] meas; // measurement this limit watches
    logic [15:0] fs; // full scale for percent values
    logic [15:0] thr_reg, thr_next;
    logic int_reg, int_next;
    logic dly_reg, dly_next;
    logic run_reg, run_next; // delay timer running
    logic [7:0] cnt_reg, cnt_next; // delay timer count
    logic [7:0] cyc_reg, cyc_next; // cycle counter
    logic pend_reg, pend_next;
    logic chg, cyc_fire, snd_new, snd_old;
    logic [23:0] prod;
    logic signed [17:0] m18, hi18, lo18;
    lvds_src_t src;
    logic [7:0] d_on, d_off, d_cyc, d_sel;

    if (g < NUM_GAS) begin : g_gas
      assign meas = gas_value;
      assign fs = GAS_FULL_SCALE;
      assign ch_on[g] =
        (ctrl_reg[CTRL_NGAS_LSB +: 3] > 3'(g));
    end else begin : g_hum
      assign meas = hum_value;
      assign fs = HUM_FULL_SCALE;
      assign ch_on[g] =
        (ctrl_reg[CTRL_NHUM_LSB +: 2] > 2'(g - NUM_GAS));
    end

    assign src = lvds_src_t'(mode_reg[g][MODE_SRC_LSB +: 2]);
    assign d_on = times_reg[g][TIMES_ON_LSB +: 8];
    assign d_off = times_reg[g][TIMES_OFF_LSB +: 8];
    assign d_cyc = times_reg[g][TIMES_CYC_LSB +: 8];

    // next threshold, states, timers and pending flag
    always_comb begin
      prod = {8'h00, ext_data[7:0]} * {8'h00, fs};
      thr_next = thr_reg;
      // download wins over a telegram in the same cycle
      if (load_pulse) begin
        thr_next = thr_cfg_reg[g][15:0];
      end else if (ext_valid && ext_index == 3'(g) &&
                   src != LVDS_SRC_NONE &&
                   ext_kind == 2'(src)) begin
        case (src)
          LVDS_SRC_ABS: thr_next = ext_data;
          LVDS_SRC_PCT: thr_next = 16'(prod / PCT_BASE);
          LVDS_SRC_TEACH: begin
            if (ext_data[0]) begin
              thr_next = meas;
            end // value 0 leaves it
          end
          default: ;
        endcase
      end
      // hysteresis comparison
      m18 = signed'({2'b00, meas});
      hi18 = signed'({2'b00, thr_reg}) +
             signed'({2'b00, thr_cfg_reg[g][31:16]});
      lo18 = signed'({2'b00, thr_reg}) -
             signed'({2'b00, thr_cfg_reg[g][31:16]});
      int_next = int_reg;
      if (!ch_on[g]) begin
        int_next = 1'b0;
      end else if (!mode_reg[g][MODE_DIR_BIT]) begin
        if (m18 < signed'({2'b00, thr_reg})) begin
          int_next = 1'b1;
        end else if (m18 > hi18) begin
          int_next = 1'b0;
        end
      end else begin
        if (m18 > signed'({2'b00, thr_reg})) begin
          int_next = 1'b1;
        end else if (m18 < lo18) begin
          int_next = 1'b0;
        end
      end
      // switch-on and switch-off delay
      dly_next = dly_reg;
      run_next = run_reg;
      cnt_next = cnt_reg;
      chg = 1'b0;
      d_sel = int_next ? d_on : d_off;
      if (int_next != int_reg) begin
        if (int_next == dly_reg) begin
          run_next = 1'b0;
        end else if (d_sel == 8'h00) begin
          dly_next = int_next;
          chg = 1'b1;
        end else begin
          run_next = 1'b1;
          cnt_next = d_sel;
        end
      end else if (run_reg && tick) begin
        if (cnt_reg == 8'h01) begin
          run_next = 1'b0;
          dly_next = int_reg;
          chg = 1'b1;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      // free cycle counter, never touched by change sends
      cyc_next = cyc_reg;
      cyc_fire = 1'b0;
      if (d_cyc == 8'h00) begin
        cyc_next = 8'h00;
      end else if (tick) begin
        if (cyc_reg >= d_cyc - 8'h01) begin
          cyc_next = 8'h00;
          cyc_fire = 1'b1;
        end else begin
          cyc_next = cyc_reg + 8'h01;
        end
      end
      // send-nothing settings gate each state
      snd_new = dly_next ? mode_reg[g][MODE_SON_BIT]
                         : mode_reg[g][MODE_SOFF_BIT];
      snd_old = dly_reg ? mode_reg[g][MODE_SON_BIT]
                        : mode_reg[g][MODE_SOFF_BIT];
      // a new request wins over the grant clearing it
      pend_next = pend_reg & ~grant[g];
      if (ch_on[g] && chg && mode_reg[g][MODE_SOC_BIT] && snd_new) begin
        pend_next = 1'b1;
      end
      if (ch_on[g] && cyc_fire && snd_old) begin
        pend_next = 1'b1;
      end
    end

    // register the limit state
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        thr_reg <= THR_RST[15:0];
        int_reg <= 1'b0;
        dly_reg <= 1'b0;
        run_reg <= 1'b0;
        cnt_reg <= 8'h00;
        cyc_reg <= 8'h00;
        pend_reg <= 1'b0;
      end else begin
        thr_reg <= thr_next;
        int_reg <= int_next;
        dly_reg <= dly_next;
        run_reg <= run_next;
        cnt_reg <= cnt_next;
        cyc_reg <= cyc_next;
        pend_reg <= pend_next;
      end
    end

    assign thr_act[g] = thr_reg;
    assign int_st[g] = int_reg;
    assign dly_st[g] = dly_reg;
    assign pend[g] = pend_reg;
  end

  // ****************************************************************
  // transmit stage
  // ****************************************************************
  lvds_tx_t tx_st_reg, tx_st_next;
  logic [2:0] idx_reg, idx_next;
  logic val_reg, val_next;
  logic take; // stage free to load a new telegram

  assign tx_valid = (tx_st_reg == LVDS_TX_BUSY);
  assign tx_index = idx_reg;
  assign tx_value = val_reg;

  // lowest pending limit goes first
  always_comb begin
    tx_st_next = tx_st_reg;
    idx_next = idx_reg;
    val_next = val_reg;
    grant = '0;
    take = 1'b0;
    case (tx_st_reg)
      LVDS_TX_IDLE: take = 1'b1;
      LVDS_TX_BUSY: take = tx_ready;
      default: take = 1'b1;
    endcase
    if (take) begin
      tx_st_next = LVDS_TX_IDLE;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (pend[i]) begin
          grant = '0;
          grant[i] = 1'b1;
          idx_next = 3'(i);
          val_next = dly_st[i];
          tx_st_next = LVDS_TX_BUSY;
        end
      end
    end
  end

  // register the transmit stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= LVDS_TX_IDLE;
      idx_reg <= 3'h0;
      val_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      idx_reg <= idx_next;
      val_reg <= val_next;
    end
  end

endmodule

// ===== tb/lvds_sva.sv
`timescale 1ns/10ps
// ****
// port checker
// ****
module lvds_sva
  import lvds_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] gas_value,
  input wire logic ext_valid,
  input wire logic [2:0] ext_index,
  input wire logic [1:0] ext_kind,
  input wire logic [15:0] ext_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [2:0] tx_index,
  input wire logic tx_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of limit 0
  logic [15:0] thr_reg, thr_next; // configured
  logic [1:0] src_reg, src_next; // source
  logic [15:0] act_reg, act_next; // in force
  logic wr_acc; // write access
  logic ext_hit; // telegram taken
  assign wr_acc = psel && penable && pwrite;
  assign ext_hit = ext_valid && ext_index == 3'h0 && src_reg != 2'h0
    && ext_kind == src_reg;
  // next shadow values, download wins
  always_comb begin
    thr_next = thr_reg;
    src_next = src_reg;
    act_next = act_reg;
    if (wr_acc && paddr == 12'h100) thr_next = pwdata[15:0];
    if (wr_acc && paddr == 12'h104) src_next = pwdata[1:0];
    if (ext_hit && src_reg == 2'h1) act_next = ext_data;
    if (ext_hit && src_reg == 2'h2) act_next = ext_data[7:0] * 16'h0028;
    if (ext_hit && src_reg == 2'h3 && ext_data[0]) act_next = gas_value;
    if (wr_acc && paddr == REG_CTRL && pwdata[CTRL_LOAD_BIT])
      act_next = thr_reg;
  end
  // shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_reg <= 16'h0000;
      src_reg <= 2'h0;
      act_reg <= 16'h0000;
    end else begin
      thr_reg <= thr_next;
      src_reg <= src_next;
      act_reg <= act_next;
    end
  end
  // ****
  // properties
  // ****
  sequence s_rd_act;
    psel && !penable && !pwrite && paddr == 12'h10C;
  endsequence
  sequence s_tx_wait;
    tx_valid && !tx_ready;
  endsequence
  property p_act;
    s_rd_act |=> prdata[15:0] == $past(act_reg);
  endproperty
  property p_hold;
    s_tx_wait |=> tx_valid && $stable(tx_index) && $stable(tx_value);
  endproperty
  property p_idx;
    tx_valid |-> tx_index < 3'h6;
  endproperty
  property p_quiet;
    $rose(presetn) |-> !tx_valid;
  endproperty
  property p_err;
    psel && !penable && paddr inside {[12'h160:12'h1FF]} |=> pslverr;
  endproperty
  property p_ok;
    psel && !penable && paddr == REG_CTRL |=> !pslverr;
  endproperty
  property p_ready;
    psel && penable |-> pready;
  endproperty
  property p_prd;
    !psel || penable |=> $stable(prdata);
  endproperty
  a_act: assert property (p_act)
    else $error("threshold in force wrong");
  a_hold: assert property (p_hold)
    else $error("telegram dropped");
  a_idx: assert property (p_idx)
    else $error("telegram index out of range");
  a_quiet: assert property (p_quiet)
    else $error("telegram at reset");
  a_err: assert property (p_err)
    else $error("no error on missing limit");
  a_ok: assert property (p_ok)
    else $error("error on control");
  a_ready: assert property (p_ready)
    else $error("no ready");
  a_prd: assert property (p_prd)
    else $error("read data moved");
endmodule
bind lvds_top lvds_sva u_lvds_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gas_value(gas_value),
  .ext_valid(ext_valid), .ext_index(ext_index), .ext_kind(ext_kind),
  .ext_data(ext_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_index(tx_index), .tx_value(tx_value)
);

// ===== tb/lvds_bus_model.sv
`timescale 1ns/10ps
// ****
// bus side: takes telegrams, tallies them
// ****
module lvds_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [2:0] tx_index,
  input wire logic tx_value,
  output logic tx_ready,
  output logic [5:0][7:0] rx_cnt,
  output logic [5:0] rx_val
);
  // ready lags the stall request by one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      rx_cnt <= '0;
      rx_val <= '0;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready && tx_index < 3'h6) begin
        rx_cnt[tx_index] <= rx_cnt[tx_index] + 8'h01;
        rx_val[tx_index] <= tx_value;
      end
    end
  end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("mismatch at %0t got %0h want %0h", $time, (a), (e)); end end
// ****
// bench top
// ****
module tb_top import lvds_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [15:0] gas_value = 16'h04D2;
  logic ext_valid = 1'b0;
  logic [1:0] ext_kind = 2'h0;
  logic [15:0] ext_data = 16'h0000;
  logic stall = 1'b0; // bus side busy
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, tx_valid, tx_ready, tx_value;
  logic [2:0] tx_index;
  logic [5:0][7:0] rx_cnt; // telegrams seen per limit
  logic [5:0] rx_val; // last value per limit
  int fails = 0;
  int compares = 0;
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  lvds_top #(.TICK_CYCLES(4)) u_lvds_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gas_value(gas_value),
    .hum_value(16'h0032), .ext_valid(ext_valid), .ext_index(3'h0),
    .ext_kind(ext_kind), .ext_data(ext_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_index(tx_index), .tx_value(tx_value));
  lvds_bus_model u_lvds_bus_model (
    .pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid),
    .tx_index(tx_index), .tx_value(tx_value), .tx_ready(tx_ready),
    .rx_cnt(rx_cnt), .rx_val(rx_val));
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  // threshold in force of limit 0
  task automatic act_chk(input logic [15:0] e);
    logic [31:0] q;
    apb(1'b0, 12'h10C, 32'h0, q);
    `CHK(q[15:0], e)
  endtask
  // one telegram for limit 0
  task automatic ext(input logic [1:0] k, input logic [15:0] d);
    @(posedge pclk);
    ext_valid <= 1'b1;
    ext_kind <= k;
    ext_data <= d;
    @(posedge pclk);
    ext_valid <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] q;
    apb(1'b0, REG_CTRL, 32'h0, q);
    `CHK(q, CTRL_RST)
    apb(1'b0, 12'h104, 32'h0, q);
    `CHK(q, MODE_RST)
    apb(1'b0, 12'h160, 32'h0, q);
    `CHK(pslverr, 1'b1)
    $display("regs test done");
  endtask
  task automatic t_ext();
    wr(12'h100, 32'h000A_0064);
    act_chk(16'h0000);
    wr(REG_CTRL, 32'h0000_0124);
    act_chk(16'h0064);
    wr(12'h104, 32'h0000_0039);
    ext(2'h2, 16'h0010);
    act_chk(16'h0064);
    ext(2'h1, 16'h01F4);
    act_chk(16'h01F4);
    wr(12'h104, 32'h0000_003A);
    ext(2'h2, 16'h000A);
    act_chk(16'h0190);
    wr(12'h104, 32'h0000_003B);
    ext(2'h3, 16'h0000);
    act_chk(16'h0190);
    ext(2'h3, 16'h0001);
    act_chk(16'h04D2);
    wr(REG_CTRL, 32'h0000_0124);
    act_chk(16'h0064);
    $display("ext test done");
  endtask
  task automatic t_delay();
    logic [31:0] q;
    logic [7:0] n;
    wr(12'h104, 32'h0000_0038);
    wr(12'h108, 32'h0000_0203);
    n = rx_cnt[0];
    gas_value <= 16'h0032;
    repeat (2) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[0], 1'b1)
    `CHK(q[8], 1'b0)
    repeat (20) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[8], 1'b1)
    `CHK(rx_cnt[0], n + 8'h01)
    gas_value <= 16'h0069;
    repeat (20) @(posedge pclk);
    n = rx_cnt[0];
    gas_value <= 16'h00C8;
    @(posedge pclk);
    gas_value <= 16'h0032;
    repeat (30) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[8], 1'b1)
    `CHK(rx_cnt[0], n)
    stall <= 1'b1;
    gas_value <= 16'h00C8;
    repeat (20) @(posedge pclk);
    `CHK(tx_valid, 1'b1)
    `CHK(rx_cnt[0], n)
    stall <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK(rx_cnt[0], n + 8'h01)
    `CHK(rx_val[0], 1'b0)
    wr(12'h108, 32'h0000_0000);
    gas_value <= 16'h0032;
    apb(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[8], 1'b1)
    $display("delay test done");
  endtask
  task automatic t_cyc();
    logic [7:0] n;
    wr(12'h104, 32'h0000_0010);
    wr(12'h108, 32'h0003_0000);
    n = rx_cnt[0];
    repeat (120) @(posedge pclk);
    n = rx_cnt[0] - n;
    `CHK(n inside {[8'h09:8'h0B]}, 1'b1)
    gas_value <= 16'h00C8;
    repeat (5) @(posedge pclk);
    n = rx_cnt[0];
    repeat (60) @(posedge pclk);
    `CHK(rx_cnt[0], n)
    gas_value <= 16'h0032;
    repeat (60) @(posedge pclk);
    `CHK(rx_cnt[0] - n >= 8'h04, 1'b1)
    wr(12'h108, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    n = rx_cnt[0];
    repeat (60) @(posedge pclk);
    `CHK(rx_cnt[0], n)
    wr(12'h104, 32'h0000_0018);
    // state 0 silent, each new state 1 sends again
    repeat (2) begin
      gas_value <= 16'h00C8;
      repeat (5) @(posedge pclk);
      gas_value <= 16'h0032;
      repeat (5) @(posedge pclk);
    end
    `CHK(rx_cnt[0], n + 8'h02)
    $display("cyclic test done");
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ext();
    t_delay();
    t_cyc();
    close_out();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end
endmodule
